// ### glc_gamma_ctl.sv
// gamma table control: register port, table banks and pixel path
// Contract
// - bank mode 11b writes both banks
// - no correction in mode 11b
// - clip on, expansion off: extra bits forced zero
// - clip on, expansion on: extra bits copy MSB
// - clip on: extra bits cleared, or copy MSB with expansion on
// - clip disabled: bits pass unmodified
// - auto increment after each data write
// - table disabled: no correction, no access
// - table enabled: follows control settings
// - address port write-only, 8-bit, resets zero
// - data write stores entry at address
// - colour select steers R, G, B, all
// - bank never display and host at once
`timescale 1ns/1ps
module glc_gamma_ctl (
   // clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [glc_pkg::PADDR_W-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // pixels in, msb aligned, with stored bits per component
   input  wire logic                        pix_valid,
   input  wire logic                        pix_pip,
   input  wire logic [glc_pkg::COMP_W-1:0]  pix_r,
   input  wire logic [glc_pkg::COMP_W-1:0]  pix_g,
   input  wire logic [glc_pkg::COMP_W-1:0]  pix_b,
   input  wire logic [3:0]                  pix_wid_r,
   input  wire logic [3:0]                  pix_wid_g,
   input  wire logic [3:0]                  pix_wid_b,
   // pixels out
   output logic                             out_valid,
   output logic      [glc_pkg::COMP_W-1:0]  out_r,
   output logic      [glc_pkg::COMP_W-1:0]  out_g,
   output logic      [glc_pkg::COMP_W-1:0]  out_b
);
   import glc_pkg::*;

   localparam int NMEM = NUM_BANK * NUM_COMP;

   logic [15:0]        ctrl;
   logic [15:0]        next_ctrl;
   logic [TBL_AW-1:0]  host_addr;
   logic [TBL_AW-1:0]  next_host_addr;
   logic [31:0]        next_prdata;
   logic               next_pready;
   logic               next_pslverr;
   logic               en;
   logic               inc;
   glc_bank_t          bank;
   glc_wcs_t           wcs;
   logic [NUM_BANK-1:0] host_own;
   logic               corr_on;
   logic               acc_done;
   logic               hit_ctrl;
   logic               hit_addr;
   logic               hit_data;
   logic               wr_addr;
   logic               wr_data;
   logic [NUM_COMP-1:0] comp_sel;
   logic [NMEM-1:0]    mem_we;
   logic [COMP_W-1:0]  rd [NMEM];
   logic [COMP_W-1:0]  host_rd;
   logic [COMP_W-1:0]  pix_c [NUM_COMP];
   logic [3:0]         wid_c [NUM_COMP];
   // pipeline: stage 1 holds the table index, stage 2 waits on the table read
   logic               v1, v2, next_v1, next_v2;
   logic               corr1, corr2, next_corr1, next_corr2;
   logic               selb1, selb2, next_selb1, next_selb2;
   logic [COMP_W-1:0]  idx1 [NUM_COMP];
   logic [COMP_W-1:0]  idx2 [NUM_COMP];
   logic [COMP_W-1:0]  next_idx1 [NUM_COMP];
   logic               next_out_valid;
   logic [COMP_W-1:0]  next_out [NUM_COMP];

   assign pix_c = '{pix_r, pix_g, pix_b};
   assign wid_c = '{pix_wid_r, pix_wid_g, pix_wid_b};

   // bits below the stored width are the extra bits
   function automatic logic [COMP_W-1:0] condition(input logic [COMP_W-1:0] v,
                                                   input logic [3:0] w,
                                                   input logic clip_dis,
                                                   input logic expand);
      logic [COMP_W-1:0] keep;
      keep = ~({COMP_W{1'b1}} >> w);
      if (clip_dis) begin
         return v;
      end
      if (expand) begin
         return (v & keep) | ({COMP_W{v[COMP_W-1]}} & ~keep);
      end
      return v & keep;
   endfunction

   // control decode
   assign en   = ctrl[EN_BIT];
   assign inc  = ctrl[INC_BIT];
   assign bank = glc_bank_t'(ctrl[BANK_LO +: 2]);
   assign wcs  = glc_wcs_t'(ctrl[WCS_LO +: 2]);

   always_comb begin
      host_own = '0;
      if (en) begin
         case (bank)
            BANK_A_DISP: host_own[BANK_B] = 1'b1;
            BANK_B_DISP: host_own[BANK_A] = 1'b1;
            BANK_HOST:   host_own = '1;
            default:     host_own = '0;
         endcase
      end
   end

   assign corr_on = en && (bank != BANK_HOST);

   always_comb begin
      case (wcs)
         WCS_RED:   comp_sel = 3'b001;
         WCS_GREEN: comp_sel = 3'b010;
         WCS_BLUE:  comp_sel = 3'b100;
         default:   comp_sel = 3'b111;
      endcase
   end

   // apb decode
   assign hit_ctrl = paddr == {CTRL_IDX, 2'b00};
   assign hit_addr = paddr == {ADDR_IDX, 2'b00};
   assign hit_data = paddr == {DATA_IDX, 2'b00};
   assign acc_done = psel && penable && pready;
   assign wr_addr  = acc_done && pwrite && hit_addr;
   assign wr_data  = acc_done && pwrite && hit_data;

   genvar gi;
   generate
      for (gi = 0; gi < NMEM; gi++) begin : g_tbl
         logic [TBL_AW-1:0] ram_addr;
         assign mem_we[gi] = wr_data && host_own[gi / NUM_COMP] && comp_sel[gi % NUM_COMP];
         assign ram_addr   = host_own[gi / NUM_COMP] ? host_addr : idx1[gi % NUM_COMP];
         glc_ram #(
            .DW (COMP_W),
            .AW (TBL_AW)
         ) u_ram (
            .clk   (pclk),
            .we    (mem_we[gi]),
            .addr  (ram_addr),
            .wdata (pwdata[COMP_W-1:0]),
            .rdata (rd[gi])
         );
      end
   endgenerate

   // host read: host bank, selected colour, red for all
   always_comb begin
      logic [1:0] c;
      logic       b;
      c = (wcs == WCS_ALL) ? 2'd0 : ctrl[WCS_LO +: 2];
      b = (bank == BANK_A_DISP) ? 1'b1 : 1'b0;
      host_rd = host_own[b] ? rd[32'(b) * NUM_COMP + 32'(c)] : '0;
   end

   // register next values; answer in the second access cycle
   always_comb begin
      next_ctrl      = ctrl;
      next_host_addr = host_addr;
      next_pready    = psel && penable && !pready;
      next_prdata    = prdata;
      next_pslverr   = 1'b0;
      if (psel && penable && !pready) begin
         next_pslverr = !(hit_ctrl || hit_addr || hit_data);
         next_prdata  = '0;
         if (hit_ctrl) begin
            next_prdata = {16'h0000, ctrl};
         end
         if (hit_data) begin
            next_prdata = {24'h00_0000, host_rd};
         end
      end
      if (acc_done && pwrite && hit_ctrl) begin
         next_ctrl = pwdata[15:0] & CTRL_MASK;
      end
      if (wr_addr) begin
         next_host_addr = pwdata[TBL_AW-1:0];
      end
      if (wr_data && inc && en) begin
         next_host_addr = host_addr + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl      <= CTRL_RST;
         host_addr <= ADDR_RST;
         pready    <= 1'b0;
         prdata    <= '0;
         pslverr   <= 1'b0;
      end else begin
         ctrl      <= next_ctrl;
         host_addr <= next_host_addr;
         pready    <= next_pready;
         prdata    <= next_prdata;
         pslverr   <= next_pslverr;
      end
   end

   // pixel path next values
   always_comb begin
      next_v1    = pix_valid;
      next_corr1 = corr_on;
      next_selb1 = (bank == BANK_B_DISP) || ((bank == BANK_SPLIT) && pix_pip);
      next_v2    = v1;
      next_corr2 = corr1;
      next_selb2 = selb1;
      next_out_valid = v2;
      for (int c = 0; c < NUM_COMP; c++) begin
         next_idx1[c] = condition(pix_c[c], wid_c[c], ctrl[CLIP_BIT], ctrl[EXP_BIT]);
         next_out[c]  = corr2 ? rd[32'(selb2) * NUM_COMP + c] : idx2[c];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         v1        <= 1'b0;
         v2        <= 1'b0;
         corr1     <= 1'b0;
         corr2     <= 1'b0;
         selb1     <= 1'b0;
         selb2     <= 1'b0;
         idx1      <= '{default: '0};
         idx2      <= '{default: '0};
         out_valid <= 1'b0;
         out_r     <= '0;
         out_g     <= '0;
         out_b     <= '0;
      end else begin
         v1        <= next_v1;
         v2        <= next_v2;
         corr1     <= next_corr1;
         corr2     <= next_corr2;
         selb1     <= next_selb1;
         selb2     <= next_selb2;
         idx1      <= next_idx1;
         idx2      <= idx1;
         out_valid <= next_out_valid;
         out_r     <= next_out[0];
         out_g     <= next_out[1];
         out_b     <= next_out[2];
      end
   end

   // checks
   addr_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_data && inc && en |=> host_addr == $past(host_addr) + 8'h01)
      else $error("table address did not advance");
   addr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_data && !inc && !wr_addr |=> $stable(host_addr))
      else $error("table address moved without increment");
   both_banks_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_data && en && bank == BANK_HOST |-> mem_we[2:0] == mem_we[5:3] && mem_we != '0)
      else $error("shared mode write missed a bank");
   no_corr_a: assert property (@(posedge pclk) disable iff (!presetn)
      pix_valid && (bank == BANK_HOST || !en) |=> ##1 !corr2)
      else $error("correction active while banks unavailable");
   off_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      !en |-> mem_we == '0)
      else $error("table written while disabled");
   all_comp_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_data && wcs == WCS_ALL && host_own[BANK_A] |-> mem_we[2:0] == 3'b111)
      else $error("all-colour write missed a component");
   zero_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
      pix_valid && !ctrl[CLIP_BIT] && !ctrl[EXP_BIT] && pix_wid_r < 4'd8 |=> idx1[0][0] == 1'b0)
      else $error("extra bit not cleared");
   msb_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
      pix_valid && !ctrl[CLIP_BIT] && ctrl[EXP_BIT] && pix_wid_g < 4'd8
      |=> idx1[1][0] == $past(pix_g[COMP_W-1]))
      else $error("extra bit not filled from msb");
   pass_thru_a: assert property (@(posedge pclk) disable iff (!presetn)
      pix_valid && ctrl[CLIP_BIT] |=> idx1[2] == $past(pix_b))
      else $error("unclipped pixel altered");
   upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready && psel && !pwrite && (hit_addr || hit_data) |-> prdata[31:8] == 24'h00_0000)
      else $error("upper port bits not zero");
   addr_wo_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready && psel && !pwrite && hit_addr |-> prdata == 32'h0000_0000)
      else $error("address port readable");
   lat_out_a: assert property (@(posedge pclk) disable iff (!presetn)
      pix_valid |=> ##2 out_valid)
      else $error("pixel output latency wrong");

   inc_burst_c: cover property (@(posedge pclk) disable iff (!presetn)
      wr_data && inc ##[1:8] wr_data && inc);
   host_read_c: cover property (@(posedge pclk) disable iff (!presetn)
      pready && hit_data && !pwrite && host_own != '0);
   corr_pix_c: cover property (@(posedge pclk) disable iff (!presetn)
      out_valid && corr2);
endmodule

// ### glc_pkg.sv
// constants, field layout and encodings for the gamma table control block
package glc_pkg;
   localparam int          PADDR_W    = 14;
   localparam int          COMP_W     = 8;
   localparam int          TBL_AW     = 8;
   localparam int          NUM_COMP   = 3;
   localparam int          NUM_BANK   = 2;
   // register indices; byte address is four times the index
   localparam logic [11:0] CTRL_IDX   = 12'h083e;
   localparam logic [11:0] ADDR_IDX   = 12'h0840;
   localparam logic [11:0] DATA_IDX   = 12'h0842;
   localparam logic [15:0] CTRL_RST   = 16'h0000;
   localparam logic [15:0] CTRL_MASK  = 16'h0f3f;
   localparam logic [7:0]  ADDR_RST   = 8'h00;
   // control field positions
   localparam int          EN_BIT     = 0;
   localparam int          INC_BIT    = 1;
   localparam int          CLIP_BIT   = 2;
   localparam int          EXP_BIT    = 3;
   localparam int          BANK_LO    = 4;
   localparam int          WCS_LO     = 8;
   localparam int          BANK_A     = 0;
   localparam int          BANK_B     = 1;
   typedef enum logic [1:0] {
      BANK_A_DISP = 2'b00,
      BANK_B_DISP = 2'b01,
      BANK_SPLIT  = 2'b10,
      BANK_HOST   = 2'b11
   } glc_bank_t;
   typedef enum logic [1:0] {
      WCS_RED   = 2'b00,
      WCS_GREEN = 2'b01,
      WCS_BLUE  = 2'b10,
      WCS_ALL   = 2'b11
   } glc_wcs_t;
endpackage

// ### glc_ram.sv
// single-port table memory with registered read data
`timescale 1ns/1ps
module glc_ram #(
   parameter int DW = 8,
   parameter int AW = 8
) (
   // clock
   input  wire logic          clk,
   // access
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem [2**AW];

   // contents are unknown until software loads them
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// ### glc_testbench.sv
// self-checking testbench for the gamma table control block
`timescale 1ns/1ps
module testbench;
   import glc_pkg::*;
   localparam logic [13:0] A_CTRL = {CTRL_IDX, 2'b00};
   localparam logic [13:0] A_ADDR = {ADDR_IDX, 2'b00};
   localparam logic [13:0] A_DATA = {DATA_IDX, 2'b00};
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [13:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pix_valid;
   logic        pix_pip;
   logic [7:0]  pix_v;
   logic [3:0]  pix_w;
   logic        out_valid;
   logic [7:0]  out_r;
   logic [7:0]  out_g;
   logic [7:0]  out_b;
   logic [31:0] rd;
   logic        rerr;
   int          bad_count;
   int          checks;

   glc_gamma_ctl i_glc_gamma_ctl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pix_valid(pix_valid), .pix_pip(pix_pip),
      .pix_r(pix_v), .pix_g(pix_v), .pix_b(pix_v), .pix_wid_r(pix_w), .pix_wid_g(pix_w),
      .pix_wid_b(pix_w), .out_valid(out_valid), .out_r(out_r), .out_g(out_g), .out_b(out_b));

   always #20 pclk = ~pclk;

   task results();
      $display("checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; waits for pready, only the watchdog ends a hang
   task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd      = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [13:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdk(input logic [13:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   function automatic logic [31:0] ctl(input logic [1:0] wcs, input logic [1:0] bank,
                                       input logic ex, input logic cd, input logic inc,
                                       input logic en);
      return {22'h00_0000, wcs, 2'b00, bank, ex, cd, inc, en};
   endfunction

   function automatic logic [7:0] lut(input int i);
      return 8'(i) ^ 8'h5a;
   endfunction

   // conditioning of bits below the stored width
   function automatic logic [7:0] cond(input logic [7:0] v, input int w, input logic cd,
                                       input logic ex);
      logic [7:0] m;
      m = 8'hff << (8 - w);
      if (cd) return v;
      if (ex && v[7]) return v | ~m;
      return v & m;
   endfunction

   // one pixel on all three components, result judged on out_valid
   task pix(input logic [7:0] v, input logic [3:0] w, input logic pip, input logic [23:0] exp);
      int n;
      @(posedge pclk);
      pix_valid <= 1'b1;
      pix_v     <= v;
      pix_w     <= w;
      pix_pip   <= pip;
      @(posedge pclk);
      pix_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (out_valid !== 1'b1 && n < 8);
      chk({31'h0, out_valid}, 32'h0000_0001);
      chk({8'h00, out_r, out_g, out_b}, {8'h00, exp});
   endtask

   task t_reset();
      rdk(A_CTRL, {16'h0000, CTRL_RST});
      rdk(A_ADDR, 32'h0000_0000);
      apb(1'b0, 14'h0010, 32'h0000_0000);
      chk({31'h0, rerr}, 32'h0000_0001);
      wr(A_CTRL, 32'hffff_ffff);
      rdk(A_CTRL, {16'h0000, CTRL_MASK});
   endtask

   task t_fill();
      wr(A_CTRL, ctl(WCS_ALL, BANK_HOST, 1'b0, 1'b0, 1'b1, 1'b1));
      wr(A_ADDR, 32'h0000_ff00);
      for (int i = 0; i < 256; i++) wr(A_DATA, 32'h0000_ab00 | lut(i));
      pix(8'h33, 4'd8, 1'b0, {3{8'h33}});
      wr(A_CTRL, ctl(WCS_ALL, BANK_A_DISP, 1'b0, 1'b0, 1'b0, 1'b1));
      wr(A_ADDR, 32'h0000_0007);
      rdk(A_DATA, {24'h00_0000, lut(7)});
      pix(8'h33, 4'd8, 1'b0, {3{lut(8'h33)}});
      wr(A_CTRL, ctl(WCS_ALL, BANK_B_DISP, 1'b0, 1'b0, 1'b0, 1'b1));
      pix(8'h33, 4'd8, 1'b0, {3{lut(8'h33)}});
   endtask

   task t_colour();
      for (int c = 0; c < 3; c++) begin
         wr(A_CTRL, ctl(2'(c), BANK_B_DISP, 1'b0, 1'b0, 1'b0, 1'b1));
         wr(A_ADDR, 32'h0000_0040);
         wr(A_DATA, 32'h0000_0010 + c);
      end
      wr(A_CTRL, ctl(WCS_GREEN, BANK_B_DISP, 1'b0, 1'b0, 1'b0, 1'b1));
      wr(A_ADDR, 32'h0000_0040);
      rdk(A_DATA, 32'h0000_0011);
      pix(8'h40, 4'd8, 1'b0, {3{lut(8'h40)}});
      wr(A_CTRL, ctl(WCS_RED, BANK_A_DISP, 1'b0, 1'b0, 1'b0, 1'b1));
      pix(8'h40, 4'd8, 1'b0, 24'h10_1112);
      wr(A_CTRL, ctl(WCS_RED, BANK_SPLIT, 1'b0, 1'b0, 1'b0, 1'b1));
      pix(8'h40, 4'd8, 1'b1, {3{lut(8'h40)}});
      pix(8'h40, 4'd8, 1'b0, 24'h10_1112);
   endtask

   task t_disable();
      wr(A_CTRL, ctl(WCS_RED, BANK_B_DISP, 1'b0, 1'b0, 1'b0, 1'b0));
      wr(A_ADDR, 32'h0000_0040);
      wr(A_DATA, 32'h0000_00ee);
      pix(8'h40, 4'd8, 1'b0, {3{8'h40}});
      wr(A_CTRL, ctl(WCS_RED, BANK_B_DISP, 1'b0, 1'b0, 1'b0, 1'b1));
      wr(A_ADDR, 32'h0000_0040);
      rdk(A_DATA, 32'h0000_0010);
   endtask

   task t_cond();
      for (int k = 0; k < 4; k++) begin
         wr(A_CTRL, ctl(WCS_RED, BANK_A_DISP, k[1], k[0], 1'b0, 1'b0));
         pix(8'haf, 4'd5, 1'b0, {3{cond(8'haf, 5, k[0], k[1])}});
         pix(8'h57, 4'd6, 1'b0, {3{cond(8'h57, 6, k[0], k[1])}});
      end
   endtask

   initial begin
      pclk      = 1'b0;
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = '0;
      pwdata    = '0;
      pix_valid = 1'b0;
      pix_pip   = 1'b0;
      pix_v     = '0;
      pix_w     = 4'd8;
      bad_count = 0;
      checks    = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_fill();
      t_colour();
      t_disable();
      t_cond();
      results();
   end

   // cut a hang short
   initial begin
      #(40 * 6000);
      bad_count++;
      results();
   end
endmodule
